//--- shared/dsrw_pkg.sv
/*
  dsrw_pkg: constants and carrier types for the dual supply reset watchdog.
  assumes a single 40 MHz free-running clock.
*/
package dsrw_pkg;
  // ==========================================================
  // timing
  // ==========================================================
  localparam longint CLK_HZ = 40000000;
  localparam longint RESET_TIMEOUT_US = 1120000;
  localparam longint WD_LONG_MS = 35000;
  localparam longint WD_SHORT_MS = 1120;
  localparam longint RESET_TIMEOUT_CYC = (CLK_HZ / 1000000) * RESET_TIMEOUT_US;
  localparam longint WD_LONG_CYC = (CLK_HZ / 1000) * WD_LONG_MS;
  localparam longint WD_SHORT_CYC = (CLK_HZ / 1000) * WD_SHORT_MS;
  localparam int CNT_W = 32;

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic primary_uv;
    logic secondary_uv;
    logic aux_uv;
    logic power_fail;
    logic manual_reset_n;
    logic kick;
  } dsrw_inputs_t;

  typedef struct packed {
    logic primary_reset_n;
    logic secondary_reset_n;
    logic power_fail_n;
  } dsrw_outputs_t;
endpackage

//--- design/dsrw_sync.sv
/*
  dsrw_sync: three-flop synchroniser, change accepted when stages two and three agree.
  assumes asynchronous inputs and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module dsrw_sync
  import dsrw_pkg::*;
#(
  parameter int W = 6,
  parameter logic [W-1:0] INIT = '0
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } dsrw_sync_st_t;

  dsrw_sync_st_t st_q;
  dsrw_sync_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.val[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= '{s1: INIT, s2: INIT, s3: INIT, val: INIT};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.val;
endmodule // dsrw_sync

//--- design/dsrw_watchdog.sv
/*
  dsrw_watchdog: reset stretching and dual-mode watchdog of a supply supervisor.
  assumes comparator flags and pins arrive asynchronously; one free-running clock.
*/
`timescale 1ns/1ps
module dsrw_watchdog
  import dsrw_pkg::*;
#(
  parameter longint RESET_CYC = RESET_TIMEOUT_CYC,
  parameter longint LONG_CYC = WD_LONG_CYC,
  parameter longint SHORT_CYC = WD_SHORT_CYC
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // comparator flags, high means below threshold
  input wire logic primary_uv_in,
  input wire logic secondary_uv_in,
  input wire logic aux_undervoltage_in,
  input wire logic power_fail_sense_in,
  // processor side
  input wire logic manual_reset_n_in,
  input wire logic watchdog_kick_in,
  // outputs
  output logic primary_reset_n_out,
  output logic secondary_reset_n_out,
  output logic power_fail_out_n
);
  // ==========================================================
  // synchronised inputs
  // ==========================================================
  dsrw_inputs_t raw;
  dsrw_inputs_t in_s;

  assign raw = '{primary_uv: primary_uv_in, secondary_uv: secondary_uv_in,
                 aux_uv: aux_undervoltage_in, power_fail: power_fail_sense_in,
                 manual_reset_n: manual_reset_n_in, kick: watchdog_kick_in};

  // undervoltage flags start as faults so both resets come up asserted
  dsrw_sync #(
    .W(6),
    .INIT(6'h3A)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(raw),
    .sync_out(in_s)
  );

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [CNT_W-1:0] pri_cnt;
    logic [CNT_W-1:0] sec_cnt;
    logic [CNT_W-1:0] wd_cnt;
    logic wd_short;
    logic kick_prev;
    dsrw_outputs_t outs;
  } dsrw_st_t;

  dsrw_st_t st_q;
  dsrw_st_t st_d;

  localparam logic [CNT_W-1:0] RESET_MAX = CNT_W'(RESET_CYC);
  localparam logic [CNT_W-1:0] LONG_MAX = CNT_W'(LONG_CYC);
  localparam logic [CNT_W-1:0] SHORT_MAX = CNT_W'(SHORT_CYC);

  // counter step used by both stretchers
  function automatic logic [CNT_W-1:0] stretch_next(input logic cause, input logic [CNT_W-1:0] c);
    if (cause)
    begin
      stretch_next = '0;
    end
    else if (c < RESET_MAX)
    begin
      stretch_next = c + CNT_W'(1);
    end
    else
    begin
      stretch_next = c;
    end
  endfunction

  logic sec_cause;
  logic wd_expire;
  logic pri_cause;
  logic kick_edge;

  always_comb
  begin
    st_d = st_q;
    sec_cause = in_s.primary_uv | in_s.secondary_uv | ~in_s.manual_reset_n;
    kick_edge = in_s.kick ^ st_q.kick_prev;
    // timer runs out once it reaches the active period
    wd_expire = st_q.wd_short ? (st_q.wd_cnt >= SHORT_MAX) : (st_q.wd_cnt >= LONG_MAX);
    pri_cause = sec_cause | in_s.aux_uv | wd_expire;
    st_d.kick_prev = in_s.kick;
    st_d.sec_cnt = stretch_next(sec_cause, st_q.sec_cnt);
    st_d.pri_cnt = stretch_next(pri_cause, st_q.pri_cnt);
    if (!st_q.outs.primary_reset_n || pri_cause)
    begin
      // held clear in reset; long mode again afterwards
      st_d.wd_cnt = '0;
      st_d.wd_short = 1'b0;
    end
    else if (kick_edge)
    begin
      st_d.wd_cnt = '0;
      st_d.wd_short = 1'b1;
    end
    else
    begin
      st_d.wd_cnt = st_q.wd_cnt + CNT_W'(1);
    end
    st_d.outs.secondary_reset_n = ~sec_cause && (st_d.sec_cnt >= RESET_MAX);
    st_d.outs.primary_reset_n = ~pri_cause && (st_d.pri_cnt >= RESET_MAX);
    st_d.outs.power_fail_n = ~in_s.power_fail;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      // power-up: both resets asserted, counters from zero
      st_q <= '{pri_cnt: '0, sec_cnt: '0, wd_cnt: '0, wd_short: 1'b0, kick_prev: 1'b0,
                outs: '{primary_reset_n: 1'b0, secondary_reset_n: 1'b0, power_fail_n: 1'b1}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign primary_reset_n_out = st_q.outs.primary_reset_n;
  assign secondary_reset_n_out = st_q.outs.secondary_reset_n;
  assign power_fail_out_n = st_q.outs.power_fail_n;

  // ==========================================================
  // checks
  // ==========================================================
  sequence s_sec_cause;
    sec_cause;
  endsequence

  property p_sec_follows;
    @(posedge mclk_in) disable iff (!rst_n_in) s_sec_cause |=> !secondary_reset_n_out;
  endproperty
  a_sec_follows: assert property (p_sec_follows) else $error("secondary reset not asserted");

  property p_sec_stretch;
    @(posedge mclk_in) disable iff (!rst_n_in)
      $fell(sec_cause) |=> !secondary_reset_n_out [*2];
  endproperty
  a_sec_stretch: assert property (p_sec_stretch) else $error("secondary reset released early");

  property p_manual;
    @(posedge mclk_in) disable iff (!rst_n_in) !in_s.manual_reset_n |=> !primary_reset_n_out;
  endproperty
  a_manual: assert property (p_manual) else $error("manual reset ignored");

  property p_wd_fire;
    @(posedge mclk_in) disable iff (!rst_n_in) wd_expire |=> !primary_reset_n_out;
  endproperty
  a_wd_fire: assert property (p_wd_fire) else $error("watchdog expiry missed");

  property p_wd_clear;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (kick_edge || !primary_reset_n_out) |=> st_q.wd_cnt == '0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog timer not cleared");

  property p_long_mode;
    @(posedge mclk_in) disable iff (!rst_n_in) !primary_reset_n_out |=> !st_q.wd_short;
  endproperty
  a_long_mode: assert property (p_long_mode) else $error("long period not restored");

  property p_short_mode;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (kick_edge && primary_reset_n_out && !pri_cause) |=> st_q.wd_short;
  endproperty
  a_short_mode: assert property (p_short_mode) else $error("short period not entered");

  property p_aux;
    @(posedge mclk_in) disable iff (!rst_n_in) in_s.aux_uv |=> !primary_reset_n_out ##1 !primary_reset_n_out;
  endproperty
  a_aux: assert property (p_aux) else $error("aux undervoltage ignored");

  property p_pfail;
    @(posedge mclk_in) disable iff (!rst_n_in) 1'b1 |=> power_fail_out_n == !$past(in_s.power_fail);
  endproperty
  a_pfail: assert property (p_pfail) else $error("power fail output wrong");

  property p_restart;
    @(posedge mclk_in) disable iff (!rst_n_in) pri_cause |=> st_q.pri_cnt == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("timeout not restarted");

  // aux and watchdog causes must leave a released secondary reset alone
  property p_sec_ignores;
    @(posedge mclk_in) disable iff (!rst_n_in)
      ((in_s.aux_uv || wd_expire) && !sec_cause && secondary_reset_n_out) |=> secondary_reset_n_out;
  endproperty
  a_sec_ignores: assert property (p_sec_ignores) else $error("secondary reset disturbed");

  property p_sec_full;
    @(posedge mclk_in) disable iff (!rst_n_in) $rose(secondary_reset_n_out) |-> st_q.sec_cnt == RESET_MAX;
  endproperty
  a_sec_full: assert property (p_sec_full) else $error("secondary stretch cut short");

  property p_pri_full;
    @(posedge mclk_in) disable iff (!rst_n_in) $rose(primary_reset_n_out) |-> st_q.pri_cnt == RESET_MAX;
  endproperty
  a_pri_full: assert property (p_pri_full) else $error("primary stretch cut short");

  sequence s_both_low;
    !primary_reset_n_out && !secondary_reset_n_out;
  endsequence

  property p_power_up;
    @(posedge mclk_in) disable iff (!rst_n_in) $rose(rst_n_in) |-> s_both_low ##1 s_both_low;
  endproperty
  a_power_up: assert property (p_power_up) else $error("resets not held after power-up");
endmodule // dsrw_watchdog

//--- testbench/dsrw_cpu.sv
/*
  dsrw_cpu: processor model that toggles the watchdog kick line.
  assumes the bench sets the kick period and may stop kicking.
*/
`timescale 1ns/1ps
module dsrw_cpu
(
  // clock and bench control
  input wire logic mclk_in,
  input wire logic kick_en_in,
  input wire logic [7:0] period_in,
  // supervisor side
  input wire logic reset_n_in,
  output logic kick_out
);
  // ==========================================================
  // kick timer
  // ==========================================================
  logic [7:0] cnt_q = 8'h00;
  logic kick_q = 1'b0;
  assign kick_out = kick_q;
  // a cpu held in reset cannot toggle its pin
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in || !kick_en_in)
      cnt_q <= 8'h00;
    else if (cnt_q >= period_in)
    begin
      cnt_q <= 8'h00;
      kick_q <= ~kick_q;
    end
    else
      cnt_q <= cnt_q + 8'h01;
  end
endmodule // dsrw_cpu

//--- testbench/dsrw_watchdog_tb.sv
/*
  dsrw_watchdog_tb: self-checking bench for the reset watchdog.
  assumes shortened periods and the dsrw_cpu kick model.
*/
`timescale 1ns/1ps
module dsrw_watchdog_tb;
  // ==========================================================
  // setup
  // ==========================================================
  localparam int RC = 20;
  localparam int LC = 200;
  localparam int SC = 50;
  typedef struct {logic v; int lo; int hi;} dsrw_note_t;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [4:0] flt = 5'h00;
  logic kick_en = 1'b1;
  logic [7:0] per = 8'h14;
  logic kick;
  logic prim_n, sec_n, pf_n;
  logic [2:0] obs;
  logic [2:0] prev = 3'h0;
  logic [31:0] rnd = 32'h00000062;
  int cyc = 0;
  int rise = 0;
  int fails = 0;
  int checks = 0;
  dsrw_note_t q[3][$];
  assign obs = {prim_n, sec_n, pf_n};

  dsrw_watchdog #(.RESET_CYC(RC), .LONG_CYC(LC), .SHORT_CYC(SC)) uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .primary_uv_in(flt[0]), .secondary_uv_in(flt[1]), .aux_undervoltage_in(flt[2]),
    .power_fail_sense_in(flt[4]), .manual_reset_n_in(~flt[3]), .watchdog_kick_in(kick),
    .primary_reset_n_out(prim_n), .secondary_reset_n_out(sec_n), .power_fail_out_n(pf_n));
  dsrw_cpu cpu (.mclk_in(mclk_in), .kick_en_in(kick_en), .period_in(per), .reset_n_in(prim_n), .kick_out(kick));

  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // ==========================================================
  // tasks
  // ==========================================================
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic note(input int id, input logic v, input int lo, input int hi);
    q[id].push_back('{v, lo, hi});
  endtask

  task automatic check_edge(input int id, input logic v);
    dsrw_note_t n;
    checks++;
    if (q[id].size() > 0)
      n = q[id].pop_front();
    else
      n = '{1'bx, 0, -1};
    if (n.v !== v || cyc < n.lo || cyc > n.hi)
    begin
      fails++;
      $display("wrong value at %0t: out %0d=%b cyc %0d", $time, id, v, cyc);
    end
  endtask

  task automatic wait_out(input int id, input logic v);
    int k;
    k = 0;
    while (obs[id] !== v && k < 2000)
    begin
      @(negedge mclk_in);
      k++;
    end
    // a wait that runs dry is a failure of its own
    if (k >= 2000)
      fails++;
    @(posedge mclk_in);
  endtask

  // one cause raised for len cycles, optionally raised again mid-timeout
  task automatic hit(input int k, input int len, input bit re);
    int t;
    @(posedge mclk_in);
    t = cyc;
    flt[k] <= 1'b1;
    if (k != 4) note(2, 1'b0, t + 2, t + 10);
    if (k != 2 && k != 4) note(1, 1'b0, t + 2, t + 10);
    if (k == 4) note(0, 1'b0, t + 2, t + 10);
    repeat (len) @(posedge mclk_in);
    flt[k] <= 1'b0;
    if (re)
    begin
      repeat (10) @(posedge mclk_in);
      flt[k] <= 1'b1;
      repeat (len) @(posedge mclk_in);
      flt[k] <= 1'b0;
    end
    t = cyc;
    if (k != 4) note(2, 1'b1, t + RC, t + RC + 12);
    if (k != 2 && k != 4) note(1, 1'b1, t + RC, t + RC + 12);
    if (k == 4) note(0, 1'b1, t + 2, t + 10);
    repeat (RC + 20) @(posedge mclk_in);
  endtask

  task automatic close_out();
    for (int i = 0; i < 3; i++) fails += q[i].size();
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // watcher and timeout
  // ==========================================================
  always @(negedge mclk_in)
  begin
    for (int i = 0; i < 3; i++)
      if (rst_n_in && obs[i] !== prev[i]) check_edge(i, obs[i]);
    if (obs[2] && !prev[2]) rise = cyc;
    prev = obs;
  end

  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000)
    begin
      fails++;
      close_out();
    end
  end

  // ==========================================================
  // scenarios
  // ==========================================================
  initial
  begin
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    note(2, 1'b1, cyc + RC, cyc + RC + 12);
    note(1, 1'b1, cyc + RC, cyc + RC + 12);
    repeat (RC + 20) @(posedge mclk_in);
    for (int i = 0; i < 5; i++)
    begin
      rnd = xs(rnd);
      per <= 8'h0A + 8'(rnd % 30);
      hit(i, 4 + int'(rnd % 8), 1'b0);
    end
    hit(0, 5, 1'b1);
    kick_en <= 1'b0;
    hit(3, 4, 1'b0);
    note(2, 1'b0, rise + LC - 2, rise + LC + 8);
    wait_out(2, 1'b0);
    note(2, 1'b1, cyc + RC - 2, cyc + RC + 8);
    wait_out(2, 1'b1);
    kick_en <= 1'b1;
    repeat (150) @(posedge mclk_in);
    kick_en <= 1'b0;
    note(2, 1'b0, cyc - per + SC - 4, cyc + SC + 10);
    wait_out(2, 1'b0);
    kick_en <= 1'b1;
    note(2, 1'b1, cyc + RC - 2, cyc + RC + 8);
    wait_out(2, 1'b1);
    repeat (20) @(posedge mclk_in);
    close_out();
  end
endmodule // dsrw_watchdog_tb
